// >>> common/cfg_opt_pkg.sv
package cfg_opt_pkg;

  // Addresses of the two option bytes in the flash space
  localparam logic [15:0] PWR_OPT_ADDR = 16'hfb00;
  localparam logic [15:0] SEC_OPT_ADDR = 16'hfb01;

  // Field positions in the power-up option byte
  localparam int WDT_CLK_BIT = 7;
  localparam int PORT_MODE_BIT = 6;
  localparam int PORT_LVL_BIT = 5;
  localparam int BOD_EN_BIT = 3;
  localparam int CLK_FILT_BIT = 2;
  localparam int OSC_HI_BIT = 1;
  localparam int OSC_LO_BIT = 0;

  // Field positions in the security option byte
  localparam int PROG_LOCK_BIT = 7;
  localparam int DATA_LOCK_BIT = 6;
  localparam int RC_FREQ_BIT = 5;
  localparam int BOV_HI_BIT = 4;
  localparam int BOV_LO_BIT = 3;
  localparam int MOVC_INH_BIT = 1;

  // Holding register contents before the load (erased flash)
  localparam logic [7:0] PWR_OPT_RST = 8'hff;
  localparam logic [7:0] SEC_OPT_RST = 8'hff;

  // Oscillator type field codes
  localparam logic [1:0] OSC_CODE_XTAL = 2'h0;
  localparam logic [1:0] OSC_CODE_IRC = 2'h1;
  localparam logic [1:0] OSC_CODE_RSVD = 2'h2;
  localparam logic [1:0] OSC_CODE_EXT = 2'h3;

  // Programmer operation and area codes
  localparam logic [1:0] PROG_OP_READ = 2'h0;
  localparam logic [1:0] PROG_OP_WRITE = 2'h1;
  localparam logic [1:0] PROG_OP_ERASE = 2'h2;
  localparam logic [1:0] PROG_OP_BANK_ERASE = 2'h3;
  localparam logic [1:0] PROG_AREA_CODE = 2'h0;
  localparam logic [1:0] PROG_AREA_DATA = 2'h1;
  localparam logic [1:0] PROG_AREA_OPTION = 2'h2;

  typedef enum logic [1:0] {
    OSC_XTAL,
    OSC_IRC,
    OSC_EXT
  } osc_sel_t;

  typedef enum logic [1:0] {
    BOV_2V6,
    BOV_3V8,
    BOV_4V5
  } bov_sel_t;

endpackage : cfg_opt_pkg

// >>> hdl/option_byte_store.sv
`timescale 1ns/100ps
`default_nettype none
module option_byte_store (
  input wire logic core_clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic wr_en, // Load strobe from the loader
  input wire logic wr_sel, // 0 power-up byte, 1 security byte
  input wire logic [7:0] wr_data, // Byte fetched from flash
  input wire logic rd_en, // Read strobe
  input wire logic rd_sel, // Byte selected for reading
  output logic [7:0] rd_data, // Registered read data
  output logic [7:0] pwr_byte, // Held power-up byte
  output logic [7:0] sec_byte // Held security byte
);

  logic [7:0] mem_r [2];

  // Two holding words, written only by the power-up loader
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_word
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
          mem_r[g] <= (g == 0) ? cfg_opt_pkg::PWR_OPT_RST
                               : cfg_opt_pkg::SEC_OPT_RST;
        else if (ce && wr_en && (wr_sel == 1'(g)))
          mem_r[g] <= wr_data;
      end
    end
  endgenerate

  // Read data registered so the read path has no flash-like glitches
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rd_data <= 8'h00;
    else if (ce && rd_en)
      rd_data <= mem_r[rd_sel];
  end

  assign pwr_byte = mem_r[0];
  assign sec_byte = mem_r[1];

endmodule : option_byte_store
`default_nettype wire

// >>> hdl/access_guard.sv
`timescale 1ns/100ps
`default_nettype none
module access_guard (
  input wire logic cfg_valid, // Option bytes loaded
  input wire logic program_area_lock, // 0 locks program flash
  input wire logic data_area_lock, // 0 locks data flash
  input wire logic table_read_inhibit, // 0 restricts external table reads
  input wire logic prog_req, // Programmer request
  input wire logic [1:0] prog_op, // Requested operation
  input wire logic [1:0] prog_area, // Targeted area
  output logic prog_grant, // Request may proceed
  output logic prog_refuse, // Request is refused
  input wire logic movc_req, // Table read request
  input wire logic movc_exec_ext, // Reader runs from external memory
  input wire logic movc_target_int, // Target lies in internal code
  output logic movc_allow, // Table read may go ahead
  output logic movc_block // Table read blocked from internal code
);

  logic ok;
  logic unlocked;
  logic code_only_locked;

  assign unlocked = program_area_lock && data_area_lock;
  assign code_only_locked = !program_area_lock && data_area_lock;

  // Programmer permission; nothing is granted until the bytes are loaded
  always_comb
  begin
    ok = 1'b0;
    if (unlocked)
      ok = 1'b1; // [R12]
    else if (code_only_locked)
    begin
      // Data area stays usable; code, option bytes, bank erase refused
      ok = (prog_area == cfg_opt_pkg::PROG_AREA_DATA) &&
           (prog_op != cfg_opt_pkg::PROG_OP_BANK_ERASE); // [R10] [R12]
    end
    else
      ok = 1'b0; // Full lock, and unsupported 1/0 treated as full lock [R11] [R13]
    prog_grant = prog_req && cfg_valid && ok;
    prog_refuse = prog_req && !(cfg_valid && ok);
  end

  // Table read guard; internal execution is refused only before cfg_valid
  always_comb
  begin
    movc_block = movc_req && movc_exec_ext && movc_target_int &&
                 !table_read_inhibit; // [R16] [R17] [R18]
    movc_allow = movc_req && cfg_valid && !movc_block;
  end

endmodule : access_guard
`default_nettype wire

// >>> hdl/config_option_decoder.sv
// Overview of operation
// [R01] Option bytes fixed at power-up, program cannot change
// [R02] Power byte bit 7 picks watchdog clock
// [R03] Bit 6 picks open-drain or quasi port reset
// [R04] Bit 5 sets port pin level during reset
// [R05] Programmer sets level bit for external execution
// [R06] Bit 3 enables brownout detect, bit 4 reserved
// [R07] Bit 2 enables the input clock filter
// [R08] Bits 1-0 select crystal, RC or external clock
// [R09] Security bit 5 selects RC frequency, default high
// [R10] Program lock 0 hides code and option bytes
// [R11] Data lock 0 hides data and option bytes
// [R12] Both unlocked open; code-only lock keeps data
// [R13] Both locked hides all; 1/0 unsupported
// [R14] Programmer sets locks only after verify
// [R15] Brownout level field: 1x 2.6V, 01 3.8V, 00 4.5V
// [R16] Inhibit 0 blocks external table reads internally
// [R17] Internal table reads always reach everything; the code allows them only once cfg_valid is high
// [R18] Inhibit 1 places no table read restriction
// [R19] Ports reset high come out quasi-bidirectional
// [R20] Load both bytes before releasing core reset
`timescale 1ns/100ps
`default_nettype none
module config_option_decoder #(
  parameter int ADDR_W = 16 // Flash address width
) (
  input wire logic core_clk, // System clock, 125 MHz
  input wire logic nrst, // Power-on reset, async, active low
  input wire logic ce, // Clock enable, freezes all state
  // Flash read port used by the power-up loader
  output logic nvm_rd_req, // Read request, held until valid
  output logic [ADDR_W-1:0] nvm_rd_addr, // Option byte address
  input wire logic nvm_rd_valid, // Read data valid pulse
  input wire logic [7:0] nvm_rd_data, // Read data
  output logic core_rst_hold, // Holds the core in reset
  output logic cfg_valid, // Decoded controls are valid
  // Running program access to the option byte addresses
  input wire logic cpu_rd_en, // Core read strobe
  input wire logic cpu_wr_en, // Core write strobe
  input wire logic [ADDR_W-1:0] cpu_addr, // Core address
  output logic [7:0] cpu_rd_data, // Option byte read data
  output logic cpu_rd_hit, // Read addressed an option byte
  output logic cpu_wr_blocked, // Write to option byte ignored
  // Decoded controls
  output logic watchdog_clock_source_sel, // 1 system clock, 0 slow RC
  output logic port_reset_mode_sel, // 1 quasi, 0 open drain
  output logic port_reset_level_sel, // 1 pins high in reset
  output logic port_reset_quasi, // Ports leave reset quasi
  output logic brownout_detect_enable, // Brownout detector on
  output logic input_clock_filter_ctl, // Clock filter on
  output logic osc_type_sel_hi, // Raw oscillator field bit 1
  output logic osc_type_sel_lo, // Raw oscillator field bit 0
  output cfg_opt_pkg::osc_sel_t osc_sel, // Decoded oscillator
  output logic osc_type_reserved, // Reserved code was read
  output logic osc_output_pin_oe, // Output pin driven by oscillator
  output logic internal_rc_freq_sel, // 1 upper RC frequency
  output logic [1:0] brownout_level_sel, // Raw brownout level field
  output cfg_opt_pkg::bov_sel_t bov_sel, // Decoded brownout level
  output logic program_area_lock, // 0 program area locked
  output logic data_area_lock, // 0 data area locked
  output logic table_read_inhibit, // 0 external table reads restricted
  // External programmer request
  input wire logic prog_req, // Programmer request
  input wire logic [1:0] prog_op, // Operation code
  input wire logic [1:0] prog_area, // Area code
  output logic prog_grant, // Request allowed
  output logic prog_refuse, // Request refused
  // Table read guard
  input wire logic movc_req, // Table read request
  input wire logic movc_exec_ext, // Executing from external memory
  input wire logic movc_target_int, // Target in internal code
  output logic movc_allow, // Table read allowed
  output logic movc_block // Table read blocked
);

  // One pass per power-up
  typedef enum logic [2:0] {
    LD_PWR_REQ,
    LD_SEC_REQ,
    LD_DONE
  } load_state_t;

  // Loader and decode state
  load_state_t state_r;
  load_state_t state_nxt;
  logic st_wr_en;
  logic st_wr_sel;
  logic cpu_hit_nxt;
  logic cpu_sel;

  logic [7:0] pwr_byte;
  logic [7:0] sec_byte;
  logic [7:0] pwr_dec;
  logic [7:0] sec_dec;

  logic cfg_valid_r;
  logic loaded;
  logic cpu_rd_hit_r;
  logic cpu_wr_blocked_r;
  logic osc_rsvd_r;
  cfg_opt_pkg::osc_sel_t osc_sel_r;
  cfg_opt_pkg::bov_sel_t bov_sel_r;
  logic [1:0] osc_code;
  logic [1:0] bov_code;

  // Loader sequence: power-up byte, then security byte, then done
  always_comb
  begin
    state_nxt = state_r;
    st_wr_en = 1'b0;
    st_wr_sel = 1'b0;
    case (state_r)
      LD_PWR_REQ:
      begin
        if (nvm_rd_valid)
        begin
          st_wr_en = 1'b1; // [R20]
          st_wr_sel = 1'b0;
          state_nxt = LD_SEC_REQ;
        end
      end
      LD_SEC_REQ:
      begin
        if (nvm_rd_valid)
        begin
          st_wr_en = 1'b1; // [R20]
          st_wr_sel = 1'b1;
          state_nxt = LD_DONE;
        end
      end
      LD_DONE:
        state_nxt = LD_DONE; // Only a new power-up reloads [R01]
      default:
        state_nxt = LD_PWR_REQ;
    endcase
  end

  // Loader state; leaves LD_DONE only through nrst
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      state_r <= LD_PWR_REQ;
    else if (ce)
      state_r <= state_nxt;
  end

  // Flash request is a level tied to the loader state
  assign nvm_rd_req = (state_r != LD_DONE);
  // Steps only on a taken byte
  assign nvm_rd_addr = (state_r == LD_SEC_REQ)
                       ? ADDR_W'(cfg_opt_pkg::SEC_OPT_ADDR)
                       : ADDR_W'(cfg_opt_pkg::PWR_OPT_ADDR);

  // Fields live once both bytes are held
  assign loaded = (state_r == LD_DONE); // [R20]

  // Core freed an edge later, after the registered
  // decodes caught up; no cycle on erased values
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      cfg_valid_r <= 1'b0;
    else if (ce && loaded)
      cfg_valid_r <= 1'b1; // [R20]
  end

  // Hold is the inverse of valid
  assign cfg_valid = cfg_valid_r;
  assign core_rst_hold = !cfg_valid_r; // Core runs only with settled options [R20]

  // Address decode for core accesses; option bytes are read-only
  // Reads wait for the valid flag
  always_comb
  begin
    cpu_sel = (cpu_addr == ADDR_W'(cfg_opt_pkg::SEC_OPT_ADDR));
    cpu_hit_nxt = (cpu_addr == ADDR_W'(cfg_opt_pkg::PWR_OPT_ADDR)) ||
                  cpu_sel;
  end

  // Loader is the only writer
  option_byte_store u_store (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .wr_en(st_wr_en),
    .wr_sel(st_wr_sel),
    .wr_data(nvm_rd_data),
    .rd_en(cpu_rd_en && cpu_hit_nxt && cfg_valid_r),
    .rd_sel(cpu_sel),
    .rd_data(cpu_rd_data),
    .pwr_byte(pwr_byte),
    .sec_byte(sec_byte)
  );

  // Read hit flag lines up with the registered read data
  // Misses leave rd_data as is
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      cpu_rd_hit_r <= 1'b0;
    else if (ce)
      cpu_rd_hit_r <= cpu_rd_en && cpu_hit_nxt && cfg_valid_r;
  end

  // Writes from the program never reach the holding words [R01]
  // Flag only; no write path
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      cpu_wr_blocked_r <= 1'b0;
    else if (ce)
      cpu_wr_blocked_r <= cpu_wr_en && cpu_hit_nxt; // [R01]
  end

  assign cpu_rd_hit = cpu_rd_hit_r;
  assign cpu_wr_blocked = cpu_wr_blocked_r;

  // Before the load completes the power-up byte shows the erased pattern and
  // the security byte reads all zeros, which keeps locks and filters in their safest state
  always_comb
  begin
    pwr_dec = loaded ? pwr_byte : cfg_opt_pkg::PWR_OPT_RST;
    sec_dec = loaded ? sec_byte : 8'h00; // Locked until loaded
  end

  // Power-up option byte fields
  assign watchdog_clock_source_sel =
    pwr_dec[cfg_opt_pkg::WDT_CLK_BIT]; // [R02]
  // Port reset behaviour
  assign port_reset_mode_sel = pwr_dec[cfg_opt_pkg::PORT_MODE_BIT]; // [R03]
  assign port_reset_level_sel = pwr_dec[cfg_opt_pkg::PORT_LVL_BIT]; // [R04]
  // High reset level forces quasi so pins only source weak current
  assign port_reset_quasi = port_reset_mode_sel ||
                            port_reset_level_sel; // [R19]
  assign brownout_detect_enable = pwr_dec[cfg_opt_pkg::BOD_EN_BIT]; // [R06]
  assign input_clock_filter_ctl = pwr_dec[cfg_opt_pkg::CLK_FILT_BIT]; // [R07]
  assign osc_type_sel_hi = pwr_dec[cfg_opt_pkg::OSC_HI_BIT];
  assign osc_type_sel_lo = pwr_dec[cfg_opt_pkg::OSC_LO_BIT];
  assign osc_code = {osc_type_sel_hi, osc_type_sel_lo};

  // Security option byte fields
  assign internal_rc_freq_sel = sec_dec[cfg_opt_pkg::RC_FREQ_BIT]; // [R09]
  assign brownout_level_sel = {sec_dec[cfg_opt_pkg::BOV_HI_BIT],
                               sec_dec[cfg_opt_pkg::BOV_LO_BIT]};
  assign bov_code = brownout_level_sel;
  // Locks are active low
  assign program_area_lock = sec_dec[cfg_opt_pkg::PROG_LOCK_BIT];
  assign data_area_lock = sec_dec[cfg_opt_pkg::DATA_LOCK_BIT];
  assign table_read_inhibit = sec_dec[cfg_opt_pkg::MOVC_INH_BIT];

  // Oscillator decode registered; reserved code falls back to crystal
  // Frozen while ce is low
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_sel_r <= cfg_opt_pkg::OSC_XTAL;
      osc_rsvd_r <= 1'b0;
    end
    else if (ce)
    begin
      case (osc_code)
        cfg_opt_pkg::OSC_CODE_XTAL:
        begin
          osc_sel_r <= cfg_opt_pkg::OSC_XTAL; // [R08]
          osc_rsvd_r <= 1'b0;
        end
        cfg_opt_pkg::OSC_CODE_IRC:
        begin
          osc_sel_r <= cfg_opt_pkg::OSC_IRC; // [R08]
          osc_rsvd_r <= 1'b0;
        end
        cfg_opt_pkg::OSC_CODE_EXT:
        begin
          osc_sel_r <= cfg_opt_pkg::OSC_EXT; // [R08]
          osc_rsvd_r <= 1'b0;
        end
        // Reserved: crystal, flagged
        cfg_opt_pkg::OSC_CODE_RSVD:
        begin
          osc_sel_r <= cfg_opt_pkg::OSC_XTAL;
          osc_rsvd_r <= loaded;
        end
        default:
        begin
          osc_sel_r <= cfg_opt_pkg::OSC_XTAL;
          osc_rsvd_r <= 1'b0;
        end
      endcase
    end
  end

  assign osc_sel = osc_sel_r;
  // Flags a misprogrammed byte
  assign osc_type_reserved = osc_rsvd_r;
  // Output pin floats with an external clock, driven otherwise
  // Registered, so glitch-free
  assign osc_output_pin_oe = (osc_sel_r != cfg_opt_pkg::OSC_EXT); // [R08]

  // Brownout level decode, upper bit dominates
  // Detector sees one clean step
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      bov_sel_r <= cfg_opt_pkg::BOV_2V6;
    else if (ce)
    begin
      case (bov_code)
        2'h2, 2'h3:
          bov_sel_r <= cfg_opt_pkg::BOV_2V6; // [R15]
        2'h1:
          bov_sel_r <= cfg_opt_pkg::BOV_3V8; // [R15]
        2'h0:
          bov_sel_r <= cfg_opt_pkg::BOV_4V5; // [R15]
        default:
          bov_sel_r <= cfg_opt_pkg::BOV_2V6;
      endcase
    end
  end

  assign bov_sel = bov_sel_r;

  // Lock and table-read enforcement
  // Early requests are refused
  access_guard u_guard (
    .cfg_valid(cfg_valid_r),
    .program_area_lock(program_area_lock),
    .data_area_lock(data_area_lock),
    .table_read_inhibit(table_read_inhibit),
    .prog_req(prog_req),
    .prog_op(prog_op),
    .prog_area(prog_area),
    .prog_grant(prog_grant), // [R10] [R11]
    .prog_refuse(prog_refuse),
    .movc_req(movc_req),
    .movc_exec_ext(movc_exec_ext),
    .movc_target_int(movc_target_int),
    .movc_allow(movc_allow), // [R17]
    .movc_block(movc_block) // [R16]
  );

endmodule : config_option_decoder
`default_nettype wire

// >>> dv/config_option_decoder_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module cfg_opt_checker #(
  parameter int ADDR_W = 16 // Flash address width
) (
  input wire logic core_clk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic ce, // Clock enable
  input wire logic nvm_rd_req, // Loader request
  input wire logic [ADDR_W-1:0] nvm_rd_addr, // Loader address
  input wire logic nvm_rd_valid, // Flash answer
  input wire logic core_rst_hold, // Core held
  input wire logic cfg_valid, // Load done
  input wire logic cpu_wr_en, // Core write
  input wire logic [ADDR_W-1:0] cpu_addr, // Core address
  input wire logic cpu_wr_blocked, // Write ignored
  input wire logic osc_type_sel_hi, // Osc field bit 1
  input wire logic osc_type_sel_lo, // Osc field bit 0
  input wire cfg_opt_pkg::osc_sel_t osc_sel, // Decoded osc
  input wire logic osc_output_pin_oe, // Osc output drive
  input wire logic [1:0] brownout_level_sel, // Level field
  input wire cfg_opt_pkg::bov_sel_t bov_sel, // Decoded level
  input wire logic program_area_lock, // Code lock
  input wire logic data_area_lock, // Data lock
  input wire logic table_read_inhibit, // Table read inhibit
  input wire logic prog_req, // Programmer request
  input wire logic prog_grant, // Granted
  input wire logic prog_refuse, // Refused
  input wire logic movc_req, // Table read
  input wire logic movc_exec_ext, // From external code
  input wire logic movc_target_int, // Into internal code
  input wire logic movc_allow, // Allowed
  input wire logic movc_block // Blocked
);
  // One domain, so clock and reset are given once
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // Load sequence and the core reset it gates
  a_hold_vs_valid: assert property (core_rst_hold == !cfg_valid)
    else $error("core hold disagrees with load state");
  a_load_quiet: assert property (cfg_valid |-> !nvm_rd_req)
    else $error("flash still read after load");
  a_addr_steps: assert property (ce && nvm_rd_req && nvm_rd_valid
    && nvm_rd_addr == cfg_opt_pkg::PWR_OPT_ADDR
    |=> nvm_rd_req && nvm_rd_addr == cfg_opt_pkg::SEC_OPT_ADDR)
    else $error("second option byte not requested next");

  // Settings stay frozen once loaded; the program cannot touch them
  a_valid_sticky: assert property (cfg_valid |=> cfg_valid)
    else $error("load state dropped without reset");
  a_fields_frozen: assert property (cfg_valid && $past(cfg_valid)
    |-> $stable({program_area_lock, data_area_lock, table_read_inhibit,
    brownout_level_sel, osc_type_sel_hi, osc_type_sel_lo}))
    else $error("decoded option changed while running");
  a_wr_refused: assert property (ce && cfg_valid && cpu_wr_en
    && (cpu_addr == cfg_opt_pkg::PWR_OPT_ADDR
    || cpu_addr == cfg_opt_pkg::SEC_OPT_ADDR) |=> cpu_wr_blocked)
    else $error("option byte write not flagged as ignored");

  // Registered decodes settle before the core is freed
  a_osc_decode: assert property (cfg_valid
    |-> osc_sel == (osc_type_sel_hi && osc_type_sel_lo ? cfg_opt_pkg::OSC_EXT
    : (!osc_type_sel_hi && osc_type_sel_lo ? cfg_opt_pkg::OSC_IRC
    : cfg_opt_pkg::OSC_XTAL))
    && osc_output_pin_oe == !(osc_type_sel_hi && osc_type_sel_lo))
    else $error("oscillator decode wrong");
  a_bov_decode: assert property (cfg_valid
    |-> bov_sel == (brownout_level_sel[1] ? cfg_opt_pkg::BOV_2V6
    : (brownout_level_sel[0] ? cfg_opt_pkg::BOV_3V8 : cfg_opt_pkg::BOV_4V5)))
    else $error("brownout level decode wrong");

  // Security and table read guards
  a_full_lock: assert property (prog_req && !program_area_lock
    && !data_area_lock |-> prog_refuse && !prog_grant)
    else $error("programmer served with both areas locked");
  a_movc_block: assert property (movc_req && movc_exec_ext
    && movc_target_int && !table_read_inhibit |-> movc_block && !movc_allow)
    else $error("external table read reached internal code");
  a_movc_inner: assert property (cfg_valid && movc_req
    && !movc_exec_ext |-> movc_allow && !movc_block)
    else $error("internal table read refused");
endmodule : cfg_opt_checker

bind config_option_decoder cfg_opt_checker #(.ADDR_W(ADDR_W)) i_chk (.*);
`default_nettype wire

// >>> dv/option_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module option_flash_model (
  input wire logic core_clk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic nvm_rd_req, // Read request
  input wire logic [15:0] nvm_rd_addr, // Byte address
  input wire logic [7:0] pwr_byte, // Stored power-up byte
  input wire logic [7:0] sec_byte, // Stored security byte
  input wire logic [1:0] lag, // Extra wait cycles
  output logic nvm_rd_valid, // Data valid pulse
  output logic [7:0] nvm_rd_data // Read data
);
  logic [1:0] wait_r;

  // Bytes arrive already verified before any lock was set
  // Between answers the bus shows the inverse of the last byte, so
  // a loader sampling late never sees stale data that looks right
  always @(negedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      nvm_rd_valid <= 1'b0;
      nvm_rd_data <= 8'h5a;
      wait_r <= 2'h0;
    end
    else if (nvm_rd_valid)
    begin
      nvm_rd_valid <= 1'b0;
      nvm_rd_data <= ~nvm_rd_data;
      wait_r <= 2'h0;
    end
    else if (nvm_rd_req && wait_r == lag)
    begin
      nvm_rd_valid <= 1'b1;
      nvm_rd_data <= (nvm_rd_addr == cfg_opt_pkg::SEC_OPT_ADDR) ?
        sec_byte : pwr_byte;
    end
    else if (nvm_rd_req)
      wait_r <= wait_r + 2'h1;
  end
endmodule : option_flash_model
`default_nettype wire

// >>> dv/config_option_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none
module config_option_decoder_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic cpu_rd_en = 1'b0;
  logic cpu_wr_en = 1'b0;
  logic prog_req = 1'b0;
  logic movc_req = 1'b0;
  logic movc_exec_ext = 1'b0;
  logic movc_target_int = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [1:0] prog_op = 2'h0;
  logic [1:0] prog_area = 2'h0;
  logic [1:0] lag = 2'h0;
  logic [7:0] pb = 8'hff;
  logic [7:0] sb = 8'hff;
  logic [15:0] nvm_rd_addr;
  logic [7:0] nvm_rd_data, cpu_rd_data;
  logic [1:0] brownout_level_sel;
  logic nvm_rd_req, nvm_rd_valid, core_rst_hold, cfg_valid, cpu_rd_hit;
  logic cpu_wr_blocked, watchdog_clock_source_sel, port_reset_mode_sel;
  logic port_reset_level_sel, port_reset_quasi, brownout_detect_enable;
  logic input_clock_filter_ctl, osc_type_sel_hi, osc_type_sel_lo;
  logic osc_type_reserved, osc_output_pin_oe, internal_rc_freq_sel;
  logic program_area_lock, data_area_lock, table_read_inhibit;
  logic prog_grant, prog_refuse, movc_allow, movc_block;
  cfg_opt_pkg::osc_sel_t osc_sel;
  cfg_opt_pkg::bov_sel_t bov_sel;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;

  config_option_decoder #(.ADDR_W(16)) i_dut (.*);
  option_flash_model i_flash (.core_clk, .nrst, .nvm_rd_req, .nvm_rd_addr,
    .pwr_byte(pb), .sec_byte(sb), .lag, .nvm_rd_valid, .nvm_rd_data);

  // 125 MHz clock
  always #4 core_clk = ~core_clk;

  // Hang guard; the full run needs well under a thousand cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [7:0] got,
    input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // Power-up load with a flash that answers after l extra cycles
  task automatic t_power_up(input logic [7:0] b0, input logic [7:0] b1,
    input logic [1:0] l);
    cfg_opt_pkg::osc_sel_t eo;
    cfg_opt_pkg::bov_sel_t eb;
    logic [7:0] got;
    @(negedge core_clk);
    nrst = 1'b0;
    pb = b0;
    sb = b1;
    lag = l;
    prog_req = 1'b1;
    repeat (20) @(negedge core_clk);
    got = {cfg_valid, core_rst_hold, prog_grant, prog_refuse, 4'h0};
    chk("in_reset", got, 8'h50);
    prog_req = 1'b0;
    nrst = 1'b1;
    for (int n = 0; n < 40 && cfg_valid !== 1'b1; n++)
      @(negedge core_clk);
    chk("loaded", {cfg_valid, core_rst_hold, nvm_rd_req, 5'h0}, 8'h80);
    @(negedge core_clk);
    got = {watchdog_clock_source_sel, port_reset_mode_sel,
      port_reset_level_sel, port_reset_quasi, brownout_detect_enable,
      input_clock_filter_ctl, osc_type_sel_hi, osc_type_sel_lo};
    chk("pwr", got, {b0[7:5], b0[6] | b0[5], b0[3:0]});
    got = {internal_rc_freq_sel, brownout_level_sel, program_area_lock,
      data_area_lock, table_read_inhibit, 2'h0};
    chk("sec", got, {b1[5], b1[4:3], b1[7:6], b1[1], 2'h0});
    eo = (b0[1:0] == 2'h3) ? cfg_opt_pkg::OSC_EXT :
      ((b0[1:0] == 2'h1) ? cfg_opt_pkg::OSC_IRC : cfg_opt_pkg::OSC_XTAL);
    eb = b1[4] ? cfg_opt_pkg::BOV_2V6 :
      (b1[3] ? cfg_opt_pkg::BOV_3V8 : cfg_opt_pkg::BOV_4V5);
    got = {osc_sel, bov_sel, osc_type_reserved, osc_output_pin_oe, 2'h0};
    chk("dec", got, {eo, eb, b0[1:0] == 2'h2, b0[1:0] != 2'h3, 2'h0});
  endtask : t_power_up

  // Write attempt first, then reads show the bytes untouched
  task automatic t_cpu_access(input logic [7:0] b0, input logic [7:0] b1);
    logic [15:0] ad [3];
    logic [7:0] ed [3];
    ad = '{cfg_opt_pkg::PWR_OPT_ADDR, cfg_opt_pkg::SEC_OPT_ADDR, 16'h1234};
    ed = '{b0, b1, b1};
    cpu_addr = cfg_opt_pkg::SEC_OPT_ADDR;
    cpu_wr_en = 1'b1;
    @(negedge core_clk);
    cpu_wr_en = 1'b0;
    chk("wr_block", {cpu_wr_blocked, 7'h0}, 8'h80);
    ce = 1'b0; // Frozen: read ignored, flag held
    cpu_rd_en = 1'b1;
    @(negedge core_clk);
    chk("ce_hold", {cpu_wr_blocked, cpu_rd_hit, 6'h0}, 8'h80);
    ce = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      cpu_addr = ad[i];
      cpu_rd_en = 1'b1;
      @(negedge core_clk);
      chk("rd_data", cpu_rd_data, ed[i]);
      chk("rd_hit", {cpu_rd_hit, 7'h0}, {i < 2, 7'h0});
      cpu_rd_en = 1'b0;
      @(negedge core_clk);
    end
  endtask : t_cpu_access

  // Every operation against every area under the loaded locks
  task automatic t_programmer(input logic [7:0] b1);
    logic g;
    for (int k = 0; k < 12; k++)
    begin
      prog_op = 2'(k / 3);
      prog_area = 2'(k % 3);
      prog_req = 1'b1;
      #1;
      g = b1[7:6] == 2'h3 || (b1[7:6] == 2'h1 && prog_op != 2'h3
        && prog_area == cfg_opt_pkg::PROG_AREA_DATA);
      chk("prog", {prog_grant, prog_refuse, 6'h0}, {g, !g, 6'h0});
      @(negedge core_clk);
    end
    prog_req = 1'b0;
  endtask : t_programmer

  // All request and target mixes of a table read; external origin only when lvl is high
  task automatic t_table_read(input logic inh, input logic lvl);
    logic b;
    for (int k = 0; k < 8; k++)
    begin
      {movc_req, movc_exec_ext, movc_target_int} = 3'(k) & {1'b1, lvl, 1'b1};
      #1;
      b = movc_req & movc_exec_ext & movc_target_int & !inh;
      chk("movc", {movc_allow, movc_block, 6'h0},
        {movc_req & !b, b, 6'h0});
      @(negedge core_clk);
    end
    movc_req = 1'b0;
  endtask : t_table_read

  // Byte pairs cover every oscillator code, level code, lock pair
  // and both inhibit values; external fetch only with level bit high
  initial
  begin
    logic [7:0] p0 [4];
    logic [7:0] p1 [4];
    p0 = '{8'hec, 8'h01, 8'h22, 8'h53};
    p1 = '{8'hff, 8'h49, 8'h20, 8'h92};
    for (int i = 0; i < 4; i++)
    begin
      t_power_up(p0[i], p1[i], 2'(i));
      t_cpu_access(p0[i], p1[i]);
      t_programmer(p1[i]);
      t_table_read(p1[i][1], p0[i][5]);
    end
    summarize();
  end
endmodule : config_option_decoder_tb
`default_nettype wire
